// ===== adc_ctrl_map.vh
`ifndef ADC_CTRL_MAP_VH
`define ADC_CTRL_MAP_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_CLOCK_DIVIDE    7'h72
`define IDX_OUTPUT_MODE     7'h73
`define IDX_POWER_MODE      7'h74
`define IDX_STATUS          7'h75

// ----------------------------------------------------------------
// Output mode fields
// ----------------------------------------------------------------
`define FMT_LSB             0
`define FMT_MSB             1
`define CMOS_BIT            2
`define DRIVE_2MA_BIT       3
`define FMT_TWOS            2'h0
`define FMT_GRAY            2'h1
`define FMT_OFFSET          2'h2
`define OUTPUT_MODE_RESET   4'h0

// ----------------------------------------------------------------
// Divide and power codes, strap levels
// ----------------------------------------------------------------
`define DIV_FROM_STRAP      2'h0
`define DIV_BY_1            2'h1
`define DIV_BY_2            2'h2
`define DIV_BY_4            2'h3
`define DIV_LSB             0
`define DIV_MSB             1
`define PWR_LSB             0
`define PWR_MSB             1
`define DIV1_TOP            2'h0
`define DIV2_TOP            2'h1
`define DIV4_TOP            2'h3
`define DLL_SLOW_BIT        2
`define PWR_FROM_STRAP      2'h0
`define PWR_NORMAL          2'h1
`define PWR_NAP             2'h2
`define PWR_SLEEP           2'h3
`define STRAP_GROUND        2'h0
`define STRAP_FLOAT         2'h1
`define STRAP_SUPPLY        2'h2

// ----------------------------------------------------------------
// Timing: relock time at the top sample rate, in sample periods
// ----------------------------------------------------------------
`define DLL_RELOCK_US       52
`define TOP_RATE_MSPS       250
`define RELOCK_SAMPLES      (`DLL_RELOCK_US * `TOP_RATE_MSPS)
`define CLK_MHZ             200
`define RATE_DIV1_MSPS      8'hc8
`define RATE_DIV2_MSPS      8'h64
`define RATE_DIV4_MSPS      8'h32
`define SLOW_MIN_MSPS       8'h28
`define SLOW_MAX_MSPS       8'h64
`define FAST_MIN_MSPS       8'h50
`define STRAP_SETTLE        2'h3

`endif

// ===== adc_output_format_power_ctrl.v
// The register addresses and register access over Avalon-MM are this design's own decisions.
`include "adc_ctrl_map.vh"

// How it works
// [RL1] Sample clock divided by two or four
// [RL2] Divide strap picks ratio at power-up
// [RL3] Register divide ratio overrides the strap
// [RL4] Relock wait after clock change, rate-scaled
// [RL5] Slow and fast delay-line ranges, fast default
// [RL6] DDR word bus, LVDS default, CMOS selectable
// [RL7] LVDS drive 3mA default, 2mA option
// [RL8] Mode and drive set at register 0x73
// [RL9] Format twos, Gray or offset binary
// [RL10] Nap or sleep floats every output
// [RL11] Power strap picks state at power-up
// [RL12] Register power mode overrides the strap
// [RL13] Host keeps clock running while powered down
// [RL14] Offset binary spans zeros to ones
// [RL15] Twos complement inverts only the top bit
// [RL16] Gray keeps top bit, XORs neighbours below
// [RL17] Receiver undoes Gray from top down
// [RL18] Full 16-bit word, format on next sample
module adc_output_format_power_ctrl #(
    parameter RELOCK_SAMPLES = `RELOCK_SAMPLES
) (
    input  wire        clk,
    input  wire        nrst,
    // Avalon-MM slave
    input  wire [8:0]  address,
    input  wire        read,
    input  wire        write,
    input  wire [31:0] writedata,
    input  wire [3:0]  byteenable,
    output reg  [31:0] readdata,
    output wire        waitrequest,
    // Three-level straps, encoded as ground, float or supply
    input  wire [1:0]  divide_ratio_strap,
    input  wire [1:0]  power_state_strap,
    // Converter core, offset binary, on this clock
    input  wire [15:0] core_code,
    input  wire        core_over_range,
    // Output pins, enables active low
    output reg  [15:0] data_out,
    output reg         data_oe_n,
    output reg         sample_output_clock,
    output reg         clock_oe_n,
    output reg         over_range,
    output reg         over_range_oe_n,
    output reg         cmos_mode,
    output reg         drive_2ma,
    output reg         dll_slow
);

    // ----------------------------------------------------------------
    // Strap synchronisers and power-up capture
    // ----------------------------------------------------------------
    reg [1:0]  div_strap_s1;
    reg [1:0]  div_strap_s2;
    reg [1:0]  pwr_strap_s1;
    reg [1:0]  pwr_strap_s2;
    reg [1:0]  settle_cnt;
    reg        straps_taken;
    reg [1:0]  div_strap_code;
    reg [1:0]  pwr_strap_code;

    // Straps are pins: two flops before any use. A pin can sit between
    // levels while its board settles, so nothing reads the first stage.
    // Reset loads the levels that mean divide by one and normal power,
    // matching what the core assumes before the straps are latched.
    always @(posedge clk) begin
        if (!nrst) begin
            div_strap_s1 <= `STRAP_FLOAT;
            div_strap_s2 <= `STRAP_FLOAT;
            pwr_strap_s1 <= `STRAP_GROUND;
            pwr_strap_s2 <= `STRAP_GROUND;
        end else begin
            div_strap_s1 <= divide_ratio_strap;
            div_strap_s2 <= div_strap_s1;
            pwr_strap_s1 <= power_state_strap;
            pwr_strap_s2 <= pwr_strap_s1;
        end
    end

    // Latch straps once the synchronisers have filled after release
    // The straps are read once only: moving one later has no effect, and
    // the override registers are the way to change ratio or power afterwards
    always @(posedge clk) begin
        if (!nrst) begin
            settle_cnt     <= 2'h0;
            straps_taken   <= 1'b0;
            div_strap_code <= `DIV_BY_1;
            pwr_strap_code <= `PWR_NORMAL;
        end else if (!straps_taken) begin
            settle_cnt <= settle_cnt + 2'h1;
            if (settle_cnt == `STRAP_SETTLE) begin
                straps_taken <= 1'b1;
                if (div_strap_s2 == `STRAP_GROUND)                          // [RL2]
                    div_strap_code <= `DIV_BY_2;
                else if (div_strap_s2 == `STRAP_SUPPLY)
                    div_strap_code <= `DIV_BY_4;
                else
                    div_strap_code <= `DIV_BY_1;
                if (pwr_strap_s2 == `STRAP_GROUND)                          // [RL11]
                    pwr_strap_code <= `PWR_NORMAL;
                else if (pwr_strap_s2 == `STRAP_SUPPLY)
                    pwr_strap_code <= `PWR_NAP;
                else
                    pwr_strap_code <= `PWR_SLEEP;
            end
        end
    end

    // ----------------------------------------------------------------
    // Register file over Avalon-MM
    // ----------------------------------------------------------------
    reg [1:0]  div_override;
    reg [1:0]  pwr_override;
    reg [1:0]  fmt_sel;
    reg        ack;
    wire [6:0] index = address[8:2];
    wire       req   = read | write;

    // One wait state: answer at the second edge of every request.
    // A fixed answer time keeps the master simple; the cost is that even
    // an unmapped word takes two cycles, and it reads back as zero.
    assign waitrequest = req & ~ack;

    // A nonzero override code wins over the strap; zero hands control back
    // to the strap that was latched after reset
    wire [1:0] eff_div = (div_override != `DIV_FROM_STRAP) ? div_override  // [RL3]
                                                           : div_strap_code;
    wire [1:0] eff_pwr = (pwr_override != `PWR_FROM_STRAP) ? pwr_override  // [RL12]
                                                           : pwr_strap_code;
    wire       powered_down = (eff_pwr == `PWR_NAP) | (eff_pwr == `PWR_SLEEP);
    // Pins stay floating until the power strap has been read, so a board
    // strapped for sleep never sees a burst of drive right after reset
    wire       float_now    = powered_down | ~straps_taken;                 // [RL11]

    // Status inputs, driven by the divider section below
    reg        dll_locked;
    wire       range_fault;

    // Handshake and read capture: the word is loaded at the taking edge and
    // stands through the answering cycle, where the master samples it
    always @(posedge clk) begin
        if (!nrst) begin
            ack      <= 1'b0;
            readdata <= 32'h0000_0000;
        end else begin
            ack <= req & ~ack;
            if (req & ~ack) begin
                readdata <= 32'h0000_0000;
                if (index == `IDX_CLOCK_DIVIDE) begin
                    readdata[2:0] <= {dll_slow, div_override};
                end else if (index == `IDX_OUTPUT_MODE) begin
                    readdata[3:0] <= {drive_2ma, cmos_mode, fmt_sel};
                end else if (index == `IDX_POWER_MODE) begin
                    readdata[1:0] <= pwr_override;
                end else if (index == `IDX_STATUS) begin
                    readdata[7:0] <= {range_fault, dll_locked, straps_taken,
                                      powered_down, eff_pwr, eff_div};
                end
            end
        end
    end

    // Control words commit at the answering edge only, where the master
    // samples waitrequest low. The low byte lane carries every field, so a
    // write with that lane off is dropped; unmapped words ignore writes.
    wire       commit = write & ack & byteenable[0];

    always @(posedge clk) begin
        if (!nrst) begin
            div_override <= `DIV_FROM_STRAP;
            pwr_override <= `PWR_FROM_STRAP;
            fmt_sel      <= `FMT_TWOS;                                      // [RL9]
            cmos_mode    <= 1'b0;                                           // [RL6]
            drive_2ma    <= 1'b0;                                           // [RL7]
            dll_slow     <= 1'b0;                                           // [RL5]
        end else if (commit) begin
            if (index == `IDX_CLOCK_DIVIDE) begin
                div_override <= writedata[`DIV_MSB:`DIV_LSB];               // [RL1]
                dll_slow     <= writedata[`DLL_SLOW_BIT];                   // [RL5]
            end else if (index == `IDX_OUTPUT_MODE) begin
                fmt_sel   <= writedata[`FMT_MSB:`FMT_LSB];                  // [RL9]
                cmos_mode <= writedata[`CMOS_BIT];                          // [RL8]
                drive_2ma <= writedata[`DRIVE_2MA_BIT];                     // [RL7]
            end else if (index == `IDX_POWER_MODE) begin
                pwr_override <= writedata[`PWR_MSB:`PWR_LSB];               // [RL12]
            end
        end
    end

    // ----------------------------------------------------------------
    // Clock divider and delay-line relock
    // ----------------------------------------------------------------
    reg  [1:0]  div_cnt;
    reg  [1:0]  last_div;
    reg  [15:0] relock_cnt;
    // Last count of the divider for each ratio; divide by one ticks every clock
    wire [1:0]  div_top = (eff_div == `DIV_BY_4) ? `DIV4_TOP :
                          (eff_div == `DIV_BY_2) ? `DIV2_TOP : `DIV1_TOP;
    wire        sample_tick = (div_cnt == div_top);

    // Sample rate in MSPS for the range check. The ranges overlap between
    // the fast floor and the slow ceiling, so either setting is legal there;
    // the flag is only a warning, the delay line is not stopped by it.
    wire [7:0]  rate_msps = (eff_div == `DIV_BY_4) ? `RATE_DIV4_MSPS :
                            (eff_div == `DIV_BY_2) ? `RATE_DIV2_MSPS : `RATE_DIV1_MSPS;
    wire        slow_ok   = (rate_msps >= `SLOW_MIN_MSPS) & (rate_msps <= `SLOW_MAX_MSPS);
    wire        fast_ok   = (rate_msps >= `FAST_MIN_MSPS);
    assign range_fault = dll_slow ? ~slow_ok : ~fast_ok;                    // [RL5]

    // Counting in sample periods makes the wait scale inversely with rate.
    // A ratio change restarts the divider from zero, so the first tick
    // after it is a full period away and never a short pulse.
    // Limitation: a change of the board clock itself is not seen here; only
    // a ratio change restarts the wait.
    always @(posedge clk) begin
        if (!nrst) begin
            div_cnt    <= 2'h0;
            last_div   <= `DIV_BY_1;
            relock_cnt <= 16'h0000;
            dll_locked <= 1'b0;
        end else if (eff_div != last_div) begin
            last_div   <= eff_div;                                          // [RL1]
            div_cnt    <= 2'h0;
            relock_cnt <= 16'h0000;
            dll_locked <= 1'b0;                                             // [RL4]
        end else begin
            div_cnt <= sample_tick ? 2'h0 : div_cnt + 2'h1;
            if (sample_tick && !dll_locked) begin
                if (relock_cnt == RELOCK_SAMPLES[15:0] - 16'h0001)          // [RL4]
                    dll_locked <= 1'b1;
                else
                    relock_cnt <= relock_cnt + 16'h0001;
            end
        end
    end

    // ----------------------------------------------------------------
    // Code format and DDR output stage
    // ----------------------------------------------------------------
    // Offset binary is the core's native code, zeros to ones
    wire [15:0] as_offset = core_code;                                      // [RL14]
    wire [15:0] as_twos   = {~core_code[15], core_code[14:0]};              // [RL15]
    wire [15:0] as_gray;
    reg  [15:0] next_data;

    // Gray: the top bit passes, every lower bit XORs its upper neighbour
    assign as_gray[15] = core_code[15];                                     // [RL16]
    genvar gb;
    generate
        for (gb = 0; gb < 15; gb = gb + 1) begin : gray_bit
            assign as_gray[gb] = core_code[gb] ^ core_code[gb + 1];         // [RL16]
        end
    endgenerate

    // Selection reads the live format, so a write shows on the next sample.
    // The unused format code falls through to two's complement, the default.
    always @* begin
        if (fmt_sel == `FMT_GRAY)
            next_data = as_gray;                                            // [RL16]
        else if (fmt_sel == `FMT_OFFSET)
            next_data = as_offset;                                          // [RL14]
        else
            next_data = as_twos;                                            // [RL18]
    end

    // One word per output clock edge; outputs float while powered down.
    // The output clock toggles once per word, so a receiver takes a word on
    // each of its edges. Electrical mode and drive strength leave on their
    // own pins for the pad ring; this block only moves the logic levels.
    always @(posedge clk) begin
        if (!nrst) begin
            data_out            <= 16'h0000;
            sample_output_clock <= 1'b0;
            over_range          <= 1'b0;
            data_oe_n           <= 1'b1;
            clock_oe_n          <= 1'b1;
            over_range_oe_n     <= 1'b1;
        end else begin
            data_oe_n       <= float_now;                                   // [RL10]
            clock_oe_n      <= float_now;
            over_range_oe_n <= float_now;
            // Holding outputs while the delay line relocks avoids torn words
            if (sample_tick && dll_locked && !float_now) begin
                data_out            <= next_data;                           // [RL6]
                over_range          <= core_over_range;
                sample_output_clock <= ~sample_output_clock;                // [RL6]
            end
        end
    end

endmodule // adc_output_format_power_ctrl

// ===== adc_capture_model.sv
// ----------------------------------------
// Receiver on the DDR output bus
// ----------------------------------------
module adc_capture_model (
    input  wire logic        clk,
    input  wire logic [15:0] data_out,
    input  wire logic        sample_output_clock,
    input  wire logic        data_oe_n,
    output logic      [15:0] word,
    output logic      [15:0] bin
);
    logic last_clk = 1'b0;
    // A floating bus shows the inverse of the last word, so a capture that
    // ignored the enable would be caught
    wire [15:0] pin_data = data_oe_n ? ~data_out : data_out;
    // One word per output clock edge, both polarities; ignore a floating bus
    always @(posedge clk) begin
        last_clk <= sample_output_clock;
        if (data_oe_n === 1'b0 && sample_output_clock !== last_clk) word <= pin_data;
    end
    // Top bit first, since each lower bit needs the one above it already recovered
    always_comb begin
        bin[15] = word[15];
        for (int i = 14; i >= 0; i--) bin[i] = bin[i + 1] ^ word[i];
    end
endmodule // adc_capture_model

// ===== adc_ctrl_asserts.sv
`include "adc_ctrl_map.vh"
module adc_ctrl_asserts (
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic [8:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic [3:0]  byteenable,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    input wire logic [15:0] data_out,
    input wire logic        data_oe_n,
    input wire logic        sample_output_clock,
    input wire logic        clock_oe_n,
    input wire logic        over_range_oe_n,
    input wire logic        cmos_mode,
    input wire logic        drive_2ma,
    input wire logic        dll_slow
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // Completed writes to the two control words
    wire wr_done  = write && !waitrequest && byteenable[0];
    wire mode_done = wr_done && address[8:2] == `IDX_OUTPUT_MODE;
    wire div_done  = wr_done && address[8:2] == `IDX_CLOCK_DIVIDE;
    a_float_together: assert property (data_oe_n == clock_oe_n && data_oe_n == over_range_oe_n)
        else $error("output enables disagree");
    a_hold_while_float: assert property (data_oe_n && $past(data_oe_n) |->
        $stable(data_out) && $stable(sample_output_clock)) else $error("floating bus moved");
    a_word_with_clock: assert property ($changed(data_out) |-> $changed(sample_output_clock))
        else $error("word changed without clock edge");
    a_one_wait: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("wait state too long");
    a_request_waits: assert property ($rose(read || write) |-> waitrequest)
        else $error("request answered at once");
    a_mode_pins: assert property (mode_done |=> cmos_mode == $past(writedata[`CMOS_BIT]) &&
        drive_2ma == $past(writedata[`DRIVE_2MA_BIT])) else $error("mode pins not updated");
    a_dll_range: assert property (div_done |=> dll_slow == $past(writedata[`DLL_SLOW_BIT]))
        else $error("range bit not updated");
    a_upper_zero: assert property (read && !waitrequest |-> readdata[31:8] == 24'h0)
        else $error("upper read bits set");
endmodule // adc_ctrl_asserts
bind adc_output_format_power_ctrl adc_ctrl_asserts u_chk (.clk, .nrst, .address, .read, .write,
    .writedata, .byteenable, .readdata, .waitrequest, .data_out, .data_oe_n, .sample_output_clock,
    .clock_oe_n, .over_range_oe_n, .cmos_mode, .drive_2ma, .dll_slow);

// ===== tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, nrst = 0, read = 0, write = 0, core_over_range = 0;
    logic [8:0] address = 9'h000;
    logic [31:0] writedata = 32'h0, q;
    logic [3:0] byteenable = 4'hf;
    logic [1:0] divide_ratio_strap = 2'h0, power_state_strap = 2'h0;
    logic [15:0] core_code = 16'h0000;
    wire [31:0] readdata;
    wire [15:0] data_out, word, bin;
    wire waitrequest, data_oe_n, sample_output_clock, clock_oe_n, over_range, over_range_oe_n;
    wire cmos_mode, drive_2ma, dll_slow;
    int error_cnt = 0, n_compared = 0, cyc = 0;
    // Clock never stops, nap and sleep included
    always #2.5 clk = ~clk;
    adc_output_format_power_ctrl #(.RELOCK_SAMPLES(4)) u_dut (.clk, .nrst, .address, .read,
        .write, .writedata, .byteenable, .readdata, .waitrequest, .divide_ratio_strap,
        .power_state_strap, .core_code, .core_over_range, .data_out, .data_oe_n,
        .sample_output_clock, .clock_oe_n, .over_range, .over_range_oe_n, .cmos_mode,
        .drive_2ma, .dll_slow);
    adc_capture_model u_cap (.clk, .data_out, .sample_output_clock, .data_oe_n, .word, .bin);
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task test_done;
        if (error_cnt == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    always @(posedge clk) if (++cyc == 20000) begin error_cnt++; test_done; end
    task check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Held from a rising edge until the rising edge that samples waitrequest low
    task bus(input logic wr, input logic [8:0] a, input logic [31:0] d);
        @(posedge clk);
        read <= !wr; write <= wr; address <= a; writedata <= d;
        do @(posedge clk); while (waitrequest !== 1'b0);
        q = readdata;
        read <= 0; write <= 0;
        @(negedge clk);
    endtask
    task reset_dut(input logic [1:0] ds, input logic [1:0] ps);
        @(posedge clk);
        divide_ratio_strap <= ds; power_state_strap <= ps; nrst <= 0;
        repeat (10) @(posedge clk);
        nrst <= 1;
        repeat (8) @(posedge clk);
    endtask
    task wait_lock;
        repeat (100) begin bus(0, 9'h1d4, 0); if (q[6] === 1'b1) break; end
        check(q[6], 1);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_defaults;
        bus(0, 9'h1cc, 0); check(q, 0);
        check({cmos_mode, drive_2ma, dll_slow}, 0);
        bus(1, 9'h000, 32'hf); bus(0, 9'h000, 0); check(q, 0);
        bus(0, 9'h1d4, 0); check(q[3:0], 4'h6);
    endtask
    task t_formats;
        logic [15:0] codes [5] = '{16'h0000, 16'h0001, 16'h8000, 16'hffff, 16'h5a3c};
        logic [15:0] v;
        wait_lock;
        for (int f = 0; f < 3; f++) begin
            bus(1, 9'h1cc, f);
            foreach (codes[k]) begin
                v = codes[k];
                @(posedge clk);
                core_code <= v; core_over_range <= v[0];
                repeat (6) @(negedge clk);
                check(word, f == 0 ? {~v[15], v[14:0]} : f == 1 ? v ^ (v >> 1) : v);
                check(over_range, v[0]);
                if (f == 1) check(bin, v);
            end
        end
    endtask
    task t_mode;
        bus(1, 9'h1cc, 32'hc); check({cmos_mode, drive_2ma}, 2'h3);
        bus(0, 9'h1cc, 0); check(q, 32'hc); bus(1, 9'h1cc, 0);
    endtask
    task t_divide;
        int n;
        logic last;
        bus(1, 9'h1c8, 3); bus(0, 9'h1d4, 0); check(q[6], 0);
        wait_lock; check(q[1:0], 2'h3);
        n = 0; last = sample_output_clock;
        repeat (32) begin @(negedge clk); n += (sample_output_clock !== last); last = sample_output_clock; end
        check(n, 8);
        bus(1, 9'h1c8, 5); check(dll_slow, 1); bus(0, 9'h1d4, 0); check(q[7], 1);
        bus(1, 9'h1c8, 0);
    endtask
    task t_power;
        bus(1, 9'h1d0, 2); repeat (2) @(negedge clk);
        check({data_oe_n, clock_oe_n, over_range_oe_n}, 3'h7);
        bus(1, 9'h1d0, 0); repeat (2) @(negedge clk); check(data_oe_n, 0);
        reset_dut(2'h1, 2'h1); bus(0, 9'h1d4, 0); check(q[4:0], 5'h1d);
        check(clock_oe_n, 1);
        reset_dut(2'h2, 2'h2); bus(0, 9'h1d4, 0); check(q[3:0], 4'hb);
    endtask
    initial begin
        reset_dut(2'h0, 2'h0);
        t_defaults; t_formats; t_mode; t_divide; t_power;
        test_done;
    end
endmodule // tb
